// >>> hdl/sas_top.sv
// successive-approximation converter sequencer with its ahb-lite register file
`timescale 1ns/10ps
`include "sas_params.svh"
module sas_top #(
	parameter int RES_W = 12
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic global_irq_enable_i,
	input wire logic cmp_i,
	output logic irq_o,
	output logic analog_enable_o,
	output logic sample_o,
	output logic [RES_W-1:0] dac_code_o,
	output logic external_reference_sel_o,
	output logic [1:0] internal_reference_sel_o,
	output logic [3:0] channel_code_o,
	output logic channel_valid_o,
	output logic [10:0] pin_analog_o
);
	// register file state
	logic [6:0] ctrl_r;
	logic conv_enable_r;
	logic conv_irq_enable_r;
	logic eoc_r;
	logic flag_r;
	logic [3:0] clk_r;
	logic [2:0] ref_r;
	logic [4:0] chan_r;
	logic [7:0] pacfg_r;
	logic [RES_W-1:0] result_r;
	// bus data phase bookkeeping
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic addr_ok;
	logic start_wr;
	logic flag_wr0;
	// sequencer state
	sas_pkg::sas_state_t state_r;
	logic [3:0] cnt_r;
	logic [3:0] bit_r;
	logic [RES_W-1:0] trial_r;
	logic tick;
	logic done;
	logic eoc_prev_r;

	// number of sampling converter clocks for a width select
	function automatic logic [3:0] sample_clks(input logic [1:0] sel);
		sample_clks = 4'd1 << sel;
	endfunction

	// lowest bit index decided for a resolution select
	function automatic logic [3:0] low_bit(input logic [1:0] res);
		if (res[1]) begin
			low_bit = 4'd0;
		end else if (res[0]) begin
			low_bit = 4'd2;
		end else begin
			low_bit = 4'd4;
		end
	endfunction

	// address phase accepted only for a valid nonseq/seq transfer
	assign addr_ok = hsel_i && hready_i && htrans_i[1];
	assign start_wr = wr_pend_r && (wr_addr_r == `SAS_OFF_CMD) && hwdata_i[`SAS_CMD_START];
	assign flag_wr0 = wr_pend_r && (wr_addr_r == `SAS_OFF_CMD) && !hwdata_i[`SAS_CMD_FLAG];
	assign done = (state_r == sas_pkg::SAS_TAIL) && tick && (cnt_r == 4'd1);

	// converter clock runs only during a conversion
	sas_clkdiv u_div (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.run_i(state_r != sas_pkg::SAS_IDLE),
		.sel_i(clk_r[`SAS_CLK_DIV_LSB +: 2]),
		.tick_o(tick)
	);

	// zero wait state slave, always okay; a write lands in its data phase
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h0_0;
			hreadyout_o <= 1'b0;
			hresp_o <= 1'b0;
		end else begin
			wr_pend_r <= addr_ok && hwrite_i;
			wr_addr_r <= haddr_i;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// read data registered at the address phase; unmapped reads as zero
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (addr_ok && !hwrite_i) begin
			if (haddr_i == `SAS_OFF_CTRL) begin
				hrdata_o <= {25'h0, ctrl_r};
			end else if (haddr_i == `SAS_OFF_CMD) begin
				hrdata_o <= {27'h0, flag_r, conv_irq_enable_r, eoc_r,
					state_r != sas_pkg::SAS_IDLE, conv_enable_r};
			end else if (haddr_i == `SAS_OFF_CLK) begin
				hrdata_o <= {28'h0, clk_r};
			end else if (haddr_i == `SAS_OFF_REF) begin
				hrdata_o <= {29'h0, ref_r};
			end else if (haddr_i == `SAS_OFF_CHAN) begin
				hrdata_o <= {27'h0, chan_r};
			end else if (haddr_i == `SAS_OFF_PACFG) begin
				hrdata_o <= {24'h0, pacfg_r};
			end else if (haddr_i == `SAS_OFF_RESULT) begin
				hrdata_o <= {{(32-RES_W){1'b0}}, result_r};
			end else begin
				hrdata_o <= 32'h0000_0000;
			end
		end
	end

	// configuration registers
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ctrl_r <= `SAS_RST_CTRL;
			clk_r <= `SAS_RST_CLK;
			ref_r <= `SAS_RST_REF;
			chan_r <= `SAS_RST_CHAN;
			pacfg_r <= `SAS_RST_PACFG;
			conv_enable_r <= 1'b0;
			conv_irq_enable_r <= 1'b0;
		end else if (wr_pend_r) begin
			if (wr_addr_r == `SAS_OFF_CTRL) begin
				ctrl_r <= {hwdata_i[6:4], 2'b00, hwdata_i[1:0]};
			end else if (wr_addr_r == `SAS_OFF_CMD) begin
				conv_enable_r <= hwdata_i[`SAS_CMD_ENABLE];
				conv_irq_enable_r <= hwdata_i[`SAS_CMD_IRQEN];
			end else if (wr_addr_r == `SAS_OFF_CLK) begin
				clk_r <= hwdata_i[3:0];
			end else if (wr_addr_r == `SAS_OFF_REF) begin
				ref_r <= hwdata_i[2:0];
			end else if (wr_addr_r == `SAS_OFF_CHAN) begin
				chan_r <= hwdata_i[4:0];
			end else if (wr_addr_r == `SAS_OFF_PACFG) begin
				pacfg_r <= hwdata_i[7:0];
			end
		end
	end

	// sequencer: sample, decide one bit per converter clock, two tail clocks
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_r <= sas_pkg::SAS_IDLE;
			cnt_r <= 4'h0;
			bit_r <= 4'h0;
			trial_r <= '0;
		end else if (!conv_enable_r) begin
			// dropping enable aborts any conversion in flight
			state_r <= sas_pkg::SAS_IDLE;
		end else begin
			case (state_r)
				sas_pkg::SAS_IDLE: begin
					// start only honoured while enabled and idle
					if (start_wr) begin
						state_r <= sas_pkg::SAS_SAMPLE;
						cnt_r <= sample_clks(clk_r[`SAS_CLK_SW_LSB +: 2]);
						trial_r <= '0;
					end
				end
				sas_pkg::SAS_SAMPLE: begin
					if (tick) begin
						if (cnt_r == 4'd1) begin
							state_r <= sas_pkg::SAS_CONV;
							bit_r <= 4'(RES_W - 1);
							trial_r <= {1'b1, {(RES_W-1){1'b0}}};
						end else begin
							cnt_r <= cnt_r - 4'd1;
						end
					end
				end
				sas_pkg::SAS_CONV: begin
					if (tick) begin
						// keep the trial bit only if the input is at or above it
						trial_r[bit_r] <= cmp_i;
						if (bit_r == low_bit(ctrl_r[`SAS_CTRL_RES_LSB +: 2])) begin
							state_r <= sas_pkg::SAS_TAIL;
							cnt_r <= {2'b00, `SAS_TAIL_CLKS};
						end else begin
							trial_r[bit_r - 4'd1] <= 1'b1;
							bit_r <= bit_r - 4'd1;
						end
					end
				end
				sas_pkg::SAS_TAIL: begin
					if (tick) begin
						if (cnt_r == 4'd1) begin
							state_r <= sas_pkg::SAS_IDLE;
						end else begin
							cnt_r <= cnt_r - 4'd1;
						end
					end
				end
				default: begin
					state_r <= sas_pkg::SAS_IDLE;
				end
			endcase
		end
	end

	// result only changes when a conversion completes
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			result_r <= '0;
		end else if (done && conv_enable_r) begin
			result_r <= trial_r;
		end
	end

	// end-of-conversion: cleared by an accepted start, set on completion
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			eoc_r <= 1'b0;
		end else if (done && conv_enable_r) begin
			eoc_r <= 1'b1;
		end else if (start_wr && conv_enable_r && state_r == sas_pkg::SAS_IDLE) begin
			eoc_r <= 1'b0;
		end
	end

	// sticky flag on the rising edge of eoc; set beats a same-cycle clear
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			eoc_prev_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			eoc_prev_r <= eoc_r;
			if (eoc_r && !eoc_prev_r) begin
				flag_r <= 1'b1;
			end else if (flag_wr0) begin
				flag_r <= 1'b0;
			end
		end
	end

	// interrupt needs both the converter and the global enable
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= flag_r && conv_irq_enable_r && global_irq_enable_i;
		end
	end

	// analog macro controls, all registered
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			analog_enable_o <= 1'b0;
			sample_o <= 1'b0;
		end else begin
			analog_enable_o <= conv_enable_r;
			sample_o <= (state_r == sas_pkg::SAS_SAMPLE);
		end
	end

	// trial code straight from its register: a second stage would lag a divide-by-one tick
	assign dac_code_o = trial_r;

	// reference, channel and pin routing
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			external_reference_sel_o <= 1'b0;
			internal_reference_sel_o <= 2'b00;
			channel_code_o <= 4'h0;
			channel_valid_o <= 1'b0;
			pin_analog_o <= 11'h000;
		end else begin
			// internal select is ignored by the macro while external is chosen
			external_reference_sel_o <= ref_r[`SAS_REF_EXT];
			internal_reference_sel_o <= ref_r[`SAS_REF_INT_LSB +: 2];
			channel_code_o <= chan_r[`SAS_CHAN_CODE_LSB +: 4];
			// codes 11xx connect nothing
			channel_valid_o <= chan_r[`SAS_CHAN_GLOBAL] &&
				(chan_r[3:0] <= `SAS_CHAN_MAX);
			pin_analog_o <= {ctrl_r[`SAS_CTRL_PIN_LSB +: 3], pacfg_r};
		end
	end
endmodule

// >>> shared/sas_params.svh
// register map, field positions, reset values and timing constants of the converter sequencer
// Contract
// - end-of-conversion flag reads zero while converting, one once finished.
// - interrupt raised on flag rising edge when converter and global interrupt enabled.
// - converter clock select 00 /16, 01 /8, 10 /1, 11 /2 of instruction clock.
// - sampling width select 00 one, 01 two, 10 four, 11 eight converter clocks.
// - resolution 00 gives 8 bits, 01 gives 10, 1x gives 12 bits.
// - one approximation bit decided per converter clock period.
// - conversion lasts sampling width plus bits plus two converter clocks.
// - external reference when its bit is one, else internal 11 supply to 00 two volts.
// - channel needs global enable; 0000-1010 pins, 1011 quarter supply, 11xx none.
// - pin analog bits make the pin a pure analog input, digital disabled.
// - interrupt flag stays set until firmware writes zero to it.
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// byte offsets on the register bus
`define SAS_OFF_CTRL 8'h00
`define SAS_OFF_CMD 8'h04
`define SAS_OFF_CLK 8'h08
`define SAS_OFF_REF 8'h0C
`define SAS_OFF_CHAN 8'h10
`define SAS_OFF_PACFG 8'h14
`define SAS_OFF_RESULT 8'h18

// command/status register fields
`define SAS_CMD_ENABLE 0
`define SAS_CMD_START 1
`define SAS_CMD_EOC 2
`define SAS_CMD_IRQEN 3
`define SAS_CMD_FLAG 4

// control register fields
`define SAS_CTRL_RES_LSB 0
`define SAS_CTRL_PIN_LSB 4

// clock register fields
`define SAS_CLK_DIV_LSB 0
`define SAS_CLK_SW_LSB 2

// reference and channel fields
`define SAS_REF_EXT 0
`define SAS_REF_INT_LSB 1
`define SAS_CHAN_CODE_LSB 0
`define SAS_CHAN_GLOBAL 4

// reset values
`define SAS_RST_CTRL 7'h00
`define SAS_RST_CLK 4'h0
`define SAS_RST_REF 3'h0
`define SAS_RST_CHAN 5'h00
`define SAS_RST_PACFG 8'h00

// converter clock divisors
`define SAS_DIV_16 5'd16
`define SAS_DIV_8 5'd8
`define SAS_DIV_1 5'd1
`define SAS_DIV_2 5'd2

// extra converter clocks after the last bit decision
`define SAS_TAIL_CLKS 2'd2
// highest valid channel code (quarter supply)
`define SAS_CHAN_MAX 4'hB

`endif

// >>> shared/sas_pkg.sv
// types shared by the converter sequencer modules
package sas_pkg;
	typedef enum logic [3:0] {
		SAS_IDLE = 4'b0001,
		SAS_SAMPLE = 4'b0010,
		SAS_CONV = 4'b0100,
		SAS_TAIL = 4'b1000
	} sas_state_t;
endpackage

// >>> hdl/sas_clkdiv.sv
// converter clock divider producing a one-cycle enable pulse
`timescale 1ns/10ps
`include "sas_params.svh"
module sas_clkdiv (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic run_i,
	input wire logic [1:0] sel_i,
	output logic tick_o
);
	logic [4:0] cnt_r;
	logic [4:0] div;

	// divisor table for the converter clock
	always_comb begin
		case (sel_i)
			2'b00: div = `SAS_DIV_16;
			2'b01: div = `SAS_DIV_8;
			2'b10: div = `SAS_DIV_1;
			default: div = `SAS_DIV_2;
		endcase
	end

	// restarts while stopped so every conversion sees full first periods
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !run_i) begin
			cnt_r <= 5'h0_0;
			tick_o <= 1'b0;
		end else if (cnt_r >= div - 5'd1) begin
			cnt_r <= 5'h0_0;
			tick_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 5'd1;
			tick_o <= 1'b0;
		end
	end
endmodule

// >>> tb/sas_top_assertions.sv
// checker on the port relations of the converter sequencer top
`timescale 1ns/10ps
`include "sas_params.svh"
module sas_top_chk #(
	parameter int RES_W = 12
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic global_irq_enable_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic irq_o,
	input wire logic analog_enable_o,
	input wire logic sample_o,
	input wire logic external_reference_sel_o,
	input wire logic [1:0] internal_reference_sel_o,
	input wire logic [3:0] channel_code_o,
	input wire logic channel_valid_o,
	input wire logic [10:0] pin_analog_o
);
	logic wr_a;
	logic cmd_wr_a;
	logic [7:0] smp_cnt_r;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// write address phases as the slave takes them
	assign wr_a = hsel_i & htrans_i[1] & hwrite_i & hreadyout_o;
	assign cmd_wr_a = wr_a & (haddr_i == `SAS_OFF_CMD);
	// length of the sampling pulse; saturates so it cannot wrap back under the bound
	// the registered tick makes the first converter period one system cycle longer
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !sample_o) begin
			smp_cnt_r <= 8'h00;
		end else if (smp_cnt_r != 8'hFF) begin
			smp_cnt_r <= smp_cnt_r + 8'h01;
		end
	end
	property p_resp_okay;
		hresp_o == 1'b0;
	endproperty
	a_resp_okay: assert property (p_resp_okay) else $error("bus response not okay");
	property p_ready_up;
		!$past(srst_i) |-> hreadyout_o;
	endproperty
	a_ready_up: assert property (p_ready_up) else $error("slave not ready");
	property p_irq_global;
		irq_o |-> $past(global_irq_enable_i);
	endproperty
	a_irq_global: assert property (p_irq_global) else $error("irq without global enable");
	property p_irq_hold;
		$fell(irq_o) |-> !$past(global_irq_enable_i) || $past(cmd_wr_a, 3);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped on its own");
	property p_chan_range;
		channel_valid_o |-> channel_code_o <= `SAS_CHAN_MAX;
	endproperty
	a_chan_range: assert property (p_chan_range) else $error("invalid channel selected");
	property p_cfg_by_write;
		$changed({pin_analog_o, channel_code_o, channel_valid_o, internal_reference_sel_o,
			external_reference_sel_o, analog_enable_o}) |-> $past(wr_a, 3);
	endproperty
	a_cfg_by_write: assert property (p_cfg_by_write) else $error("setting moved alone");
	property p_sample_len;
		smp_cnt_r <= 8'h81;
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sampling too long");
	property p_sample_gap;
		$fell(sample_o) && analog_enable_o |-> !sample_o [*8];
	endproperty
	a_sample_gap: assert property (p_sample_gap) else $error("sampling restarted early");
endmodule

// >>> tb/sas_macro_model.sv
// behavioural analog macro: comparator of a held level against the trial code
`timescale 1ns/10ps
module sas_macro_model (
	input wire logic clk_sys_i,
	input wire logic analog_enable_i,
	input wire logic [11:0] level_i,
	input wire logic [11:0] dac_code_i,
	output logic cmp_o
);
	logic junk_r = 1'b0;
	// a powered-down macro gives no steady answer
	always @(posedge clk_sys_i) junk_r <= ~junk_r;
	// keeps the trial bit when the level is at or above the trial code
	assign cmp_o = analog_enable_i ? (level_i >= dac_code_i) : junk_r;
endmodule

// >>> tb/tb_top.sv
// self-checking bench: registers, settings outputs and timed conversions
`timescale 1ns/10ps
`include "sas_params.svh"
module tb_top;
	typedef struct {logic [31:0] exp; logic [31:0] msk;} sas_note_t;
	logic clk_sys_i = 1'b0, srst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, global_irq_enable = 1'b0;
	logic [7:0] haddr_i = 8'h00;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] hwdata_i = 32'h0000_0000, rng = 32'h0001_65BF, rdata;
	logic [11:0] level = 12'h000, res = 12'h000, dac;
	logic rdy, irq, aen, smp, cmp, ext, cv, rd_dp_r = 1'b0;
	logic [1:0] iref;
	logic [3:0] ccode;
	logic [10:0] pins;
	logic [7:0] offs [5] = '{`SAS_OFF_CTRL, `SAS_OFF_CLK, `SAS_OFF_REF, `SAS_OFF_CHAN, 8'h14};
	logic [31:0] msks [5] = '{32'h73, 32'hF, 32'h7, 32'h1F, 32'hFF};
	logic [31:0] v [5];
	int divs [4] = '{16, 8, 1, 2}, sws [4] = '{1, 2, 4, 8}, bits [4] = '{8, 10, 12, 12};
	int n_fail = 0, compares = 0, cyc = 0, t0, lo;
	sas_note_t q[$];
	sas_top #(.RES_W(12)) i_sas_top (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(rdy), .hrdata_o(rdata), .hreadyout_o(rdy), .hresp_o(),
		.global_irq_enable_i(global_irq_enable), .cmp_i(cmp), .irq_o(irq), .analog_enable_o(aen),
		.sample_o(smp), .dac_code_o(dac), .external_reference_sel_o(ext),
		.internal_reference_sel_o(iref), .channel_code_o(ccode), .channel_valid_o(cv),
		.pin_analog_o(pins));
	sas_macro_model i_sas_macro_model (.clk_sys_i(clk_sys_i), .analog_enable_i(aen),
		.level_i(level), .dac_code_i(dac), .cmp_o(cmp));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one single word; idle cycle first, each phase held until ready is seen at an edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= wr;
		@(posedge clk_sys_i);
		while (rdy !== 1'b1) @(posedge clk_sys_i);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		@(posedge clk_sys_i);
		while (rdy !== 1'b1) @(posedge clk_sys_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		q.push_back('{e, m});
		bus(1'b0, a, 32'h0000_0000);
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// read data is taken at the edge that ends its data phase, against the oldest note
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (rd_dp_r && rdy === 1'b1) begin
			chk("hrdata", rdata & q[0].msk, q[0].exp);
			void'(q.pop_front());
		end
		if (rdy === 1'b1) rd_dp_r <= hsel_i & htrans_i[1] & !hwrite_i;
	end
	// watchdog well beyond the bias wait plus the slowest conversions
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		foreach (offs[i]) rd(offs[i], 32'h0, 32'hFFFF_FFFF);
		rd(8'h1C, 32'h0, 32'hFFFF_FFFF);
		// random words into every writable field but the command ones, read back through the field mask
		for (int i = 0; i < 5; i++) begin
			rng = xs(rng);
			v[i] = rng & msks[i];
			bus(1'b1, offs[i], rng);
			rd(offs[i], v[i], msks[i]);
		end
		chk("pins", pins, {v[0][6:4], v[4][7:0]});
		// every channel code with the global enable off and on, every reference code
		for (int c = 0; c < 32; c++) begin
			bus(1'b1, `SAS_OFF_CHAN, c);
			bus(1'b1, `SAS_OFF_REF, c[2:0]);
			repeat (2) @(posedge clk_sys_i);
			chk("valid", cv, c[4] && c[3:0] <= 4'hB);
			chk("code", ccode, c[3:0]);
			chk("ref", {iref, ext}, c[2:0]);
		end
		bus(1'b1, `SAS_OFF_PACFG, 32'h0000_0001);
		bus(1'b1, `SAS_OFF_CHAN, 32'h0000_0010);
		bus(1'b1, `SAS_OFF_CMD, 32'h0000_0019);
		repeat (25600) @(posedge clk_sys_i);
		global_irq_enable <= 1'b1;
		// each select code once: resolution, clock divider and sampling width
		for (int k = 0; k < 4; k++) begin
			rng = xs(rng);
			level <= rng[11:0];
			bus(1'b1, `SAS_OFF_CTRL, k);
			bus(1'b1, `SAS_OFF_CLK, {k[1:0], k[1:0]});
			t0 = cyc;
			bus(1'b1, `SAS_OFF_CMD, 32'h0000_001B);
			rd(`SAS_OFF_CMD, 32'h0000_0002, 32'h0000_0006);
			rd(`SAS_OFF_RESULT, res, 32'hFFFF_FFFF);
			bus(1'b1, `SAS_OFF_CMD, 32'h0000_001B);
			while (irq !== 1'b1 && cyc - t0 < 2000) @(posedge clk_sys_i);
			lo = (sws[k] + bits[k] + 2) * divs[k];
			chk("time", cyc - t0 >= lo && cyc - t0 <= lo + divs[k] + 8, 1'b1);
			res = rng[11:0] & (12'hFFF << (12 - bits[k]));
			rd(`SAS_OFF_RESULT, res, 32'hFFFF_FFFF);
			rd(`SAS_OFF_CMD, 32'h0000_0014, 32'h0000_0016);
			global_irq_enable <= 1'b0;
			repeat (2) @(posedge clk_sys_i);
			chk("irq off", irq, 1'b0);
			global_irq_enable <= 1'b1;
			repeat (2) @(posedge clk_sys_i);
			chk("irq back", irq, 1'b1);
			bus(1'b1, `SAS_OFF_CMD, 32'h0000_0009);
			repeat (3) @(posedge clk_sys_i);
			chk("irq clear", irq, 1'b0);
		end
		print_verdict();
	end
endmodule
bind sas_top sas_top_chk #(.RES_W(RES_W)) i_sas_top_chk (.clk_sys_i(clk_sys_i),
	.srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .global_irq_enable_i(global_irq_enable_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .irq_o(irq_o), .analog_enable_o(analog_enable_o), .sample_o(sample_o),
	.external_reference_sel_o(external_reference_sel_o),
	.internal_reference_sel_o(internal_reference_sel_o), .channel_code_o(channel_code_o),
	.channel_valid_o(channel_valid_o), .pin_analog_o(pin_analog_o));
